// ### common/ocd_pkg.sv
package ocd_pkg;

  // opcodes
  localparam logic [7:0] OP_TEST   = 8'h00;
  localparam logic [7:0] OP_TAP    = 8'h06;
  localparam logic [7:0] OP_FLG2ACC = 8'h07;
  localparam logic [7:0] OP_BSET   = 8'h14;
  localparam logic [7:0] OP_TAB    = 8'h16;
  localparam logic [7:0] OP_TBA    = 8'h17;
  localparam logic [7:0] OP_PREFIX = 8'h18;
  localparam logic [7:0] OP_BRA    = 8'h20;
  localparam logic [7:0] OP_STK2IDX   = 8'h30;
  localparam logic [7:0] OP_IDX2STK   = 8'h35;
  localparam logic [7:0] OP_IDLE_IRQ  = 8'h3e;
  localparam logic [7:0] OP_SOFT_TRAP = 8'h3f;
  localparam logic [7:0] OP_TSTA   = 8'h4d;
  localparam logic [7:0] OP_TSTB   = 8'h5d;
  localparam logic [7:0] OP_TSTI   = 8'h6d;
  localparam logic [7:0] OP_TSTE   = 8'h7d;
  localparam logic [7:0] OP_LDAI   = 8'h86;
  localparam logic [7:0] OP_XGD    = 8'h8f;
  localparam logic [7:0] OP_LDAD   = 8'h96;
  localparam logic [7:0] OP_LDDI   = 8'hcc;

  // cycle counts per instruction, plus the first and last push cycle of stacking
  localparam logic [3:0] CYC_IMPL  = 4'h2;
  localparam logic [3:0] CYC_XFER  = 4'h3;
  localparam logic [3:0] CYC_TSTM  = 4'h6;
  localparam logic [3:0] CYC_LDAD  = 4'h3;
  localparam logic [3:0] CYC_LDDI  = 4'h3;
  localparam logic [3:0] CYC_BRA   = 4'h3;
  localparam logic [3:0] CYC_BSET  = 4'h6;
  localparam logic [3:0] CYC_PRE   = 4'h1;
  localparam logic [3:0] CYC_STACK = 4'hc;
  localparam logic [3:0] PUSH_FIRST = 4'h2;
  localparam logic [3:0] PUSH_LAST  = 4'ha;

  // flag register bit positions
  localparam int CC_S = 7;
  localparam int CC_X = 6;
  localparam int CC_I = 4;
  localparam int CC_N = 3;
  localparam int CC_Z = 2;
  localparam int CC_V = 1;
  localparam int CC_C = 0;

  localparam logic [7:0]  FLAGS_RST = 8'hd0;
  localparam logic [15:0] SP_RST    = 16'h00ff;
  localparam logic [15:0] START_RST = 16'h0000;

  // apb map
  localparam logic [7:0] R_CTRL   = 8'h00;
  localparam logic [7:0] R_START  = 8'h04;
  localparam logic [7:0] R_STATUS = 8'h08;
  localparam logic [7:0] R_ACCD   = 8'h0c;
  localparam logic [7:0] R_INDEX  = 8'h10;
  localparam logic [7:0] R_SPPC   = 8'h14;
  localparam logic [7:0] R_FLAGS  = 8'h18;
  localparam logic [7:0] R_IDLE   = 8'h1c;
  localparam int CTRL_RUN   = 0;
  localparam int CTRL_TMODE = 1;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_EXEC  = 6'h02,
    ST_STACK = 6'h04,
    ST_WAIT  = 6'h08,
    ST_VECT  = 6'h10,
    ST_TEST  = 6'h20
  } ocd_state_t;

  typedef enum logic [3:0] {
    C_NOP, C_TAP, C_F2A, C_TAB, C_TBA, C_TSTA, C_TSTB, C_TSTM,
    C_S2I, C_I2S, C_XGD, C_LDAI, C_LDAM, C_LDDI, C_BRA, C_BSET
  } ocd_cls_t;

  typedef enum logic [2:0] {M_NONE, M_DIR, M_EXT, M_IDX, M_REL} ocd_mode_t;
  typedef enum logic [2:0] {F_KEEP, F_TST, F_LD8, F_LD16, F_TAP, F_SEI} ocd_fop_t;

  typedef struct packed {
    ocd_cls_t  cls;
    ocd_mode_t mode;
    logic [1:0] nopr;
    logic [3:0] total;
  } ocd_dec_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } ocd_mem_t;

endpackage

// ### src/ocd_ea_unit.sv
`timescale 1ns/1ps
module ocd_ea_unit
  import ocd_pkg::*;
(
  input  wire ocd_mode_t   mode,
  input  wire logic [7:0]  b1,
  input  wire logic [7:0]  b2,
  input  wire logic [15:0] idx,
  input  wire logic [15:0] pc,
  output logic      [15:0] ea
);
  wire logic [15:0] ea_dir = {8'h00, b1};
  wire logic [15:0] ea_ext = {b1, b2};
  wire logic [15:0] ea_idx = idx + {8'h00, b1};
  wire logic [15:0] ea_rel = pc + {{8{b1[7]}}, b1};

  assign ea = (mode == M_DIR) ? ea_dir :
              (mode == M_EXT) ? ea_ext :
              (mode == M_IDX) ? ea_idx : ea_rel;
endmodule

// ### src/ocd_flag_unit.sv
`timescale 1ns/1ps
module ocd_flag_unit
  import ocd_pkg::*;
(
  input  wire ocd_fop_t    fop,
  input  wire logic [15:0] val,
  input  wire logic [7:0]  acc,
  input  wire logic [7:0]  ccr_in,
  output logic      [7:0]  ccr_out
);
  wire logic z8  = (val[7:0] == 8'h00);
  wire logic z16 = (val == 16'h0000);

  always_comb begin
    ccr_out = ccr_in;
    case (fop)
      F_TST: begin
        ccr_out[CC_N] = val[7];
        ccr_out[CC_Z] = z8;
        ccr_out[CC_V] = 1'b0;
        ccr_out[CC_C] = 1'b0;
      end
      F_LD8: begin
        ccr_out[CC_N] = val[7];
        ccr_out[CC_Z] = z8;
        ccr_out[CC_V] = 1'b0;
      end
      F_LD16: begin
        ccr_out[CC_N] = val[15];
        ccr_out[CC_Z] = z16;
        ccr_out[CC_V] = 1'b0;
      end
      F_TAP: begin
        ccr_out       = acc;
        ccr_out[CC_X] = acc[CC_X] & ccr_in[CC_X];
      end
      F_SEI: ccr_out[CC_I] = 1'b1;
      default: ;
    endcase
  end
endmodule

// ### src/ocd_core.sv
`timescale 1ns/1ps
module ocd_core
  import ocd_pkg::*;
#(
  parameter logic [15:0] TRAP_VEC = 16'hfff6, // arbitrary default
  parameter logic [15:0] IRQ_VEC = 16'hfff2   // arbitrary default
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output ocd_mem_t         mem_req,
  input  wire logic [7:0]  mem_rdata,
  input  wire logic        irq_n
);

  function automatic ocd_dec_t ocd_decode(input logic pre, input logic [7:0] op);
    ocd_dec_t d;
    d = '{cls: C_NOP, mode: M_NONE, nopr: 2'd0, total: CYC_IMPL};
    case (op)
      OP_TAP:  d.cls = C_TAP;
      OP_FLG2ACC: d.cls = C_F2A;
      OP_TAB:  d.cls = C_TAB;
      OP_TBA:  d.cls = C_TBA;
      OP_TSTA: d.cls = C_TSTA;
      OP_TSTB: d.cls = C_TSTB;
      OP_TSTE: d = '{cls: C_TSTM, mode: M_EXT, nopr: 2'd2, total: CYC_TSTM};
      OP_TSTI: d = '{cls: C_TSTM, mode: M_IDX, nopr: 2'd1, total: CYC_TSTM};
      OP_STK2IDX: d = '{cls: C_S2I, mode: M_NONE, nopr: 2'd0, total: CYC_XFER};
      OP_IDX2STK: d = '{cls: C_I2S, mode: M_NONE, nopr: 2'd0, total: CYC_XFER};
      OP_XGD:  d = '{cls: C_XGD, mode: M_NONE, nopr: 2'd0, total: CYC_XFER};
      OP_LDAI: d = '{cls: C_LDAI, mode: M_NONE, nopr: 2'd1, total: CYC_IMPL};
      OP_LDAD: d = '{cls: C_LDAM, mode: M_DIR, nopr: 2'd1, total: CYC_LDAD};
      OP_LDDI: d = '{cls: C_LDDI, mode: M_NONE, nopr: 2'd2, total: CYC_LDDI};
      OP_BRA:  d = '{cls: C_BRA, mode: M_REL, nopr: 2'd1, total: CYC_BRA};
      OP_BSET: d = '{cls: C_BSET, mode: M_DIR, nopr: 2'd2, total: CYC_BSET};
      default: ;
    endcase
    if (pre) begin
      d.total = d.total + CYC_PRE;
    end
    return d;
  endfunction

  ocd_state_t  st_q, st_d;
  logic [3:0]  cnt_q;
  logic        have_q, pre_q, mrd_q, vsel_q, vswi_q;
  logic [1:0]  nf_q;
  logic [7:0]  op_q, opr0_q, opr1_q, md_q, vhi_q;
  logic [15:0] idle_q, tcnt_q;
  logic [7:0]  a_q, b_q, a_d, b_d, ccr_q, ccr_d;
  logic [15:0] x_q, y_q, sp_q, pc_q, x_d, y_d, sp_d, pc_d;
  logic        run_q, tmode_q, perr_q;
  logic [15:0] start_q;
  logic [31:0] prdata_q;
  logic [2:0]  sync_q;
  logic        irq_q;
  ocd_dec_t    dec;
  ocd_fop_t    fop;
  logic [15:0] ea, fval;

  assign dec = ocd_decode(pre_q, op_q);

  wire logic is_idle  = (st_q == ST_IDLE);
  wire logic is_exec  = (st_q == ST_EXEC);
  wire logic is_stack = (st_q == ST_STACK);
  wire logic is_wait  = (st_q == ST_WAIT);
  wire logic is_vect  = (st_q == ST_VECT);
  wire logic is_test  = (st_q == ST_TEST);

  wire logic [15:0] idx = pre_q ? y_q : x_q;
  wire logic opfetch  = is_exec & ~have_q;
  wire logic op_pre   = opfetch & ~pre_q & (mem_rdata == OP_PREFIX);
  wire logic op_trap  = opfetch & ~pre_q &
                        (mem_rdata == OP_SOFT_TRAP || mem_rdata == OP_IDLE_IRQ);
  // without test mode the test opcode falls through decode as a no-op
  wire logic op_test  = opfetch & ~pre_q & (mem_rdata == OP_TEST) & tmode_q;
  wire logic need_opr = is_exec & have_q & (nf_q < dec.nopr);
  wire logic rd_mode  = (dec.mode == M_DIR) | (dec.mode == M_EXT) | (dec.mode == M_IDX);
  wire logic need_mem = is_exec & have_q & ~need_opr & rd_mode & ~mrd_q;
  wire logic commit   = is_exec & have_q & ((cnt_q + 4'h1) == dec.total);
  wire logic fetch    = opfetch | need_opr;
  wire logic bset_wr  = commit & (dec.cls == C_BSET);
  wire logic pushing  = is_stack & (cnt_q >= PUSH_FIRST) & (cnt_q <= PUSH_LAST);
  wire logic irq_take = is_wait & irq_q & ~ccr_q[CC_I];

  // operand bytes are forwarded straight from the bus in the cycle they arrive
  wire logic [7:0] b1 = (need_opr && nf_q == 2'd0) ? mem_rdata : opr0_q;
  wire logic [7:0] b2 = (need_opr && nf_q == 2'd1) ? mem_rdata : opr1_q;
  wire logic [7:0] md = need_mem ? mem_rdata : md_q;

  wire logic [3:0]  push_idx = cnt_q - PUSH_FIRST;
  wire logic [71:0] stk      = {ccr_q, b_q, a_q, x_q, y_q, pc_q};
  wire logic [7:0]  push_b   = stk[{push_idx, 3'b000} +: 8];
  wire logic [15:0] vaddr    = (vswi_q ? TRAP_VEC : IRQ_VEC) + {15'h0000, vsel_q};

  ocd_ea_unit u_ea (
    .mode (dec.mode),
    .b1   (b1),
    .b2   (b2),
    .idx  (idx),
    .pc   (pc_q),
    .ea   (ea)
  );

  assign mem_req.rd    = fetch | need_mem | is_vect | is_test;
  assign mem_req.wr    = bset_wr | pushing;
  assign mem_req.addr  = fetch ? pc_q :
                         (need_mem | bset_wr) ? ea :
                         pushing ? sp_q :
                         is_vect ? vaddr : tcnt_q;
  assign mem_req.wdata = pushing ? push_b : (md_q | opr1_q);

  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_IDLE:  if (run_q) st_d = ST_EXEC;
      ST_EXEC: begin
        if (op_trap) begin
          st_d = ST_STACK;
        end else if (op_test) begin
          st_d = ST_TEST;
        end else if (commit && !run_q) begin
          st_d = ST_IDLE;
        end
      end
      ST_STACK: if (cnt_q == CYC_STACK - 4'h1) st_d = vswi_q ? ST_VECT : ST_WAIT;
      ST_WAIT:  if (irq_take) st_d = ST_VECT;
      ST_VECT:  if (vsel_q) st_d = ST_EXEC;
      ST_TEST:  st_d = ST_TEST;
      default:  st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q  <= ST_IDLE;
      cnt_q <= 4'h0;
    end else begin
      st_q  <= st_d;
      cnt_q <= (commit || !(is_exec || is_stack)) ? 4'h0 : cnt_q + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      have_q <= 1'b0;
      pre_q  <= 1'b0;
      op_q   <= 8'h00;
      nf_q   <= 2'd0;
      opr0_q <= 8'h00;
      opr1_q <= 8'h00;
      md_q   <= 8'h00;
      mrd_q  <= 1'b0;
    end else begin
      if (opfetch && !op_pre) op_q <= mem_rdata;
      if (op_pre) pre_q <= 1'b1;
      if (opfetch && !op_pre && !op_trap && !op_test) have_q <= 1'b1;
      if (need_opr && nf_q == 2'd0) opr0_q <= mem_rdata;
      if (need_opr && nf_q == 2'd1) opr1_q <= mem_rdata;
      if (need_opr) nf_q <= nf_q + 2'd1;
      if (need_mem) begin
        md_q  <= mem_rdata;
        mrd_q <= 1'b1;
      end
      if (commit || op_trap) begin
        have_q <= 1'b0;
        pre_q  <= 1'b0;
        nf_q   <= 2'd0;
        mrd_q  <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vsel_q <= 1'b0;
      vswi_q <= 1'b0;
      vhi_q  <= 8'h00;
      idle_q <= 16'h0000;
      tcnt_q <= 16'h0000;
    end else begin
      if (op_trap) vswi_q <= (mem_rdata == OP_SOFT_TRAP);
      if (is_vect) vsel_q <= ~vsel_q;
      if (is_vect && !vsel_q) vhi_q <= mem_rdata;
      if (op_trap) idle_q <= 16'h0000;
      else if (is_wait) idle_q <= idle_q + 16'h0001;
      if (op_test) tcnt_q <= pc_q + 16'h0001;
      else if (is_test) tcnt_q <= tcnt_q + 16'h0001;
    end
  end

  assign fval = (dec.cls == C_TSTA || dec.cls == C_TAB) ? {8'h00, a_q} :
                (dec.cls == C_TSTB || dec.cls == C_TBA) ? {8'h00, b_q} :
                (dec.cls == C_TSTM || dec.cls == C_LDAM) ? {8'h00, md} :
                (dec.cls == C_LDAI) ? {8'h00, b1} : {b1, b2};
  // stack/index transfers, exchange and flag copy map to F_KEEP; TAB and TBA update the flags via F_LD8
  assign fop = (is_vect && vsel_q) ? F_SEI :
               !commit ? F_KEEP :
               (dec.cls == C_TSTA || dec.cls == C_TSTB || dec.cls == C_TSTM) ? F_TST :
               (dec.cls == C_TAB || dec.cls == C_TBA) ? F_LD8 :
               (dec.cls == C_LDAI || dec.cls == C_LDAM) ? F_LD8 :
               (dec.cls == C_LDDI) ? F_LD16 :
               (dec.cls == C_TAP) ? F_TAP : F_KEEP;

  ocd_flag_unit u_flag (
    .fop     (fop),
    .val     (fval),
    .acc     (a_q),
    .ccr_in  (ccr_q),
    .ccr_out (ccr_d)
  );

  always_comb begin
    a_d  = a_q;
    b_d  = b_q;
    x_d  = x_q;
    y_d  = y_q;
    sp_d = sp_q;
    pc_d = pc_q;
    if (is_idle && run_q) pc_d = start_q;
    if (fetch) pc_d = pc_q + 16'h0001;
    if (pushing) sp_d = sp_q - 16'h0001;
    if (is_vect && vsel_q) pc_d = {vhi_q, mem_rdata};
    if (commit) begin
      case (dec.cls)
        C_TAB:  b_d = a_q;
        C_TBA:  a_d = b_q;
        C_F2A:  a_d = ccr_q;
        C_S2I:  if (pre_q) y_d = sp_q + 16'h0001; else x_d = sp_q + 16'h0001;
        C_I2S:  sp_d = idx - 16'h0001;
        C_XGD: begin
          {a_d, b_d} = idx;
          if (pre_q) y_d = {a_q, b_q}; else x_d = {a_q, b_q};
        end
        C_LDAI: a_d = b1;
        C_LDAM: a_d = md;
        C_LDDI: {a_d, b_d} = {b1, b2};
        C_BRA:  pc_d = ea;
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_q   <= 8'h00;
      b_q   <= 8'h00;
      x_q   <= 16'h0000;
      y_q   <= 16'h0000;
      sp_q  <= SP_RST;
      pc_q  <= 16'h0000;
      ccr_q <= FLAGS_RST;
    end else begin
      a_q   <= a_d;
      b_q   <= b_d;
      x_q   <= x_d;
      y_q   <= y_d;
      sp_q  <= sp_d;
      pc_q  <= pc_d;
      ccr_q <= ccr_d;
    end
  end

  // a level counts only once the last two stages agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_q <= 3'b111;
      irq_q  <= 1'b0;
    end else begin
      sync_q <= {sync_q[1:0], irq_n};
      if (sync_q[1] == sync_q[2]) irq_q <= ~sync_q[2];
    end
  end

  wire logic apb_setup = psel & ~penable;
  wire logic apb_wr    = psel & penable & pwrite;
  wire logic mapped    = (paddr == R_CTRL) | (paddr == R_START) | (paddr == R_STATUS) |
                         (paddr == R_ACCD) | (paddr == R_INDEX) | (paddr == R_SPPC) |
                         (paddr == R_FLAGS) | (paddr == R_IDLE);
  wire logic [31:0] rd_word =
    (paddr == R_CTRL)   ? {30'h0, tmode_q, run_q} :
    (paddr == R_START)  ? {16'h0000, start_q} :
    (paddr == R_STATUS) ? {26'h0, st_q} :
    (paddr == R_ACCD)   ? {16'h0000, a_q, b_q} :
    (paddr == R_INDEX)  ? {y_q, x_q} :
    (paddr == R_SPPC)   ? {pc_q, sp_q} :
    (paddr == R_FLAGS)  ? {24'h0, ccr_q} :
    (paddr == R_IDLE)   ? {16'h0000, idle_q} : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q    <= 1'b0;
      tmode_q  <= 1'b0;
      start_q  <= START_RST;
      prdata_q <= 32'h0;
      perr_q   <= 1'b0;
    end else begin
      if (apb_setup) begin
        prdata_q <= rd_word;
        perr_q   <= ~mapped;
      end
      if (apb_wr && paddr == R_CTRL) begin
        run_q   <= pwdata[CTRL_RUN];
        tmode_q <= pwdata[CTRL_TMODE];
      end
      if (apb_wr && paddr == R_START) start_q <= pwdata[15:0];
    end
  end

  assign prdata  = prdata_q;
  assign pready  = 1'b1;
  assign pslverr = perr_q & psel & penable;

  wire logic [15:0] rel_ext = {{8{opr0_q[7]}}, opr0_q};

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_idle_stack_len: assert property (op_trap && mem_rdata == OP_IDLE_IRQ
    |-> ##11 st_q == ST_STACK ##1 st_q == ST_WAIT) else $error("wait stacking length wrong");
  a_wait_idle_hold: assert property (is_wait && !irq_q |=> is_wait && !mem_req.rd)
    else $error("left wait without interrupt");
  a_vect_two_cyc: assert property (irq_take |=> is_vect ##1 is_vect ##1 opfetch)
    else $error("vector fetch not two cycles");
  a_test_counts: assert property (is_test |=> is_test && mem_req.rd
    && mem_req.addr == $past(mem_req.addr) + 16'h0001) else $error("test bus not counting");
  a_dir_page_zero: assert property (need_mem && dec.mode == M_DIR
    |-> mem_req.addr == {8'h00, opr0_q}) else $error("direct high byte not zero");
  a_idx_unsigned: assert property (need_mem && dec.mode == M_IDX
    |-> mem_req.addr == idx + {8'h00, opr0_q}) else $error("indexed offset wrong");
  a_rel_target: assert property (commit && dec.cls == C_BRA
    |=> pc_q == $past(pc_q) + $past(rel_ext)) else $error("relative target wrong");
  a_ext_byte_order: assert property (need_mem && dec.mode == M_EXT
    |-> mem_req.addr == {opr0_q, opr1_q}) else $error("extended byte order wrong");
  a_imm16_order: assert property (commit && dec.cls == C_LDDI
    |=> a_q == $past(opr0_q) && b_q == $past(mem_rdata)) else $error("imm16 order wrong");
  a_imm8_value: assert property (commit && dec.cls == C_LDAI
    |=> a_q == $past(mem_rdata)) else $error("imm8 value wrong");
  a_mask_bits: assert property (bset_wr |-> mem_req.wr
    && (mem_req.wdata & ~opr1_q) == (md_q & ~opr1_q) && (mem_req.wdata & opr1_q) == opr1_q)
    else $error("mask write wrong");
  a_tap_x_never_set: assert property (commit && dec.cls == C_TAP && !ccr_q[CC_X]
    |=> !ccr_q[CC_X]) else $error("flag transfer set X");
  a_prefix_cycles: assert property (commit && pre_q
    && (dec.cls == C_S2I || dec.cls == C_I2S || dec.cls == C_XGD) |-> cnt_q == 4'h3)
    else $error("prefixed transfer cycle count wrong");
  a_tst_clears_vc: assert property (commit && fop == F_TST
    |=> !ccr_q[CC_V] && !ccr_q[CC_C]) else $error("zero-minus check left V or C");
  a_trap_sets_i: assert property (is_vect && vsel_q |=> ccr_q[CC_I])
    else $error("trap did not set I");

  c_wai_irq: cover property (irq_take ##1 is_vect ##1 is_vect);
  c_soft_trap: cover property (op_trap && mem_rdata == OP_SOFT_TRAP);
  c_test_run: cover property (is_test ##1 is_test);
  c_bset_wr: cover property (bset_wr);

endmodule

// ### testbench/tb_cpu_opcode_operand_decode.sv
`timescale 1ns/1ps
module tb_cpu_opcode_operand_decode
  import ocd_pkg::*;
;
  localparam logic [15:0] VEC = 16'hfff2;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        irq_n = 1'b1;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, r;
  logic        pready, pslverr, err;
  ocd_mem_t    mem_req;
  logic [7:0]  mem [0:65535];
  logic [7:0]  jj, kk, v, ll, dd, mm, old;
  logic [15:0] a1;
  logic [31:0] seed = 67;
  int          fail_count = 0;
  int          checked = 0;
  int          tick = 0;
  int          cyc = 0, t0 = 0, t1 = 0, t2 = 0, t3 = 0, tw = 0;

  ocd_core #(.IRQ_VEC(VEC)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_req(mem_req), .mem_rdata(mem[mem_req.addr]),
    .irq_n(irq_n));

  initial begin
    forever #12.5 pclk = ~pclk;
  end

  // memory answers in the same cycle, so reads are combinational from the array
  always @(posedge pclk) begin
    if (mem_req.wr) mem[mem_req.addr] <= mem_req.wdata;
    tick++;
    if (tick == 20000) begin
      fail_count++;
      complete_run();
    end
  end

  // bus timeline, sampled mid-cycle where the request has settled
  always @(negedge pclk) begin
    cyc++;
    if (mem_req.rd && mem_req.addr == 16'h0408) t0 = cyc;
    if (mem_req.rd && mem_req.addr == VEC) t1 = cyc;
    if (mem_req.rd && mem_req.addr == VEC + 16'h1) t2 = cyc;
    if (mem_req.rd && mem_req.addr == 16'h0500 && t3 == 0) t3 = cyc;
    if (mem_req.wr) tw = cyc;
  end

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  function automatic logic [7:0] tstf(input logic [7:0] c, input logic [7:0] x);
    return {c[7:4], x[7], x == 8'h00, 2'b00};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(r, e);
  endtask

  task automatic prog(input logic [15:0] a, input logic [7:0] q[$]);
    foreach (q[i]) mem[a + 16'(i)] = q[i];
  endtask

  // every program, or for 0x0400 its interrupt handler at 0x0500, ends in a branch-to-self, so stopping lands on a known pc
  task automatic run(input logic [15:0] a);
    apb(1'b1, R_START, {16'h0, a});
    apb(1'b1, R_CTRL, 32'h1);
    repeat (60) @(posedge pclk);
    apb(1'b1, R_CTRL, 32'h0);
    do apb(1'b0, R_STATUS, 32'h0); while (r[5:0] !== 6'h01);
    $display("program at %h done", a);
  endtask

  initial begin
    foreach (mem[i]) mem[i] = 8'h01;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(R_STATUS, 32'h01);
    rd(R_FLAGS, 32'hd0);
    rd(R_SPPC, 32'h000000ff);
    rd(8'h20, 32'h0);
    chk(err, 32'h1);
    $display("reset and map test done");
    for (int i = 0; i < 2; i++) begin
      jj = rnd();
      kk = rnd();
      dd = rnd() & 8'h7f;
      v = (i == 0) ? 8'h00 : (rnd() | 8'h80);
      mem[dd] = v;
      prog(16'h0100, {8'hcc, jj, kk, 8'h96, dd, 8'h4d, 8'h20, 8'hfe});
      run(16'h0100);
      rd(R_ACCD, {16'h0, v, kk});
      rd(R_FLAGS, {24'h0, tstf(8'hd0, v)});
      rd(R_SPPC, 32'h010600ff);
    end
    mem[16'h10ff] = 8'h00;
    prog(16'h0200, {8'hcc, 8'h10, 8'h00, 8'h8f, 8'h6d, 8'hff, 8'h20, 8'hfe});
    run(16'h0200);
    rd(R_INDEX, 32'h00001000);
    rd(R_ACCD, 32'h0);
    rd(R_FLAGS, 32'hd4);
    jj = rnd();
    kk = rnd();
    ll = rnd();
    mm = rnd();
    old = rnd();
    dd = 8'h80 | (rnd() & 8'h3f);
    mem[dd] = old;
    mem[{8'h30, ll}] = 8'h80;
    prog(16'h0300, {8'hcc, jj, kk, 8'h14, dd, mm, 8'h7d, 8'h30, ll, 8'h18, 8'h8f,
                    8'h20, 8'h01, 8'h86, 8'h20, 8'hfe});
    run(16'h0300);
    chk(mem[dd], old | mm);
    rd(R_FLAGS, 32'hd8);
    rd(R_INDEX, {jj, kk, 16'h1000});
    rd(R_ACCD, 32'h0);
    mem[VEC] = 8'h05;
    mem[VEC + 16'h1] = 8'h00;
    prog(16'h0500, {8'h20, 8'hfe});
    prog(16'h0400, {8'h86, 8'h00, 8'h06, 8'h86, 8'h4c, 8'h06, 8'h07, 8'h16, 8'h3e});
    irq_n <= 1'b0;
    run(16'h0400);
    irq_n <= 1'b1;
    rd(R_ACCD, 32'h00000c0c);
    rd(R_FLAGS, 32'h10);
    rd(R_SPPC, 32'h050000f6);
    chk({mem[16'h00fe], mem[16'h00ff]}, 32'h0409);
    chk({mem[16'h00f9], mem[16'h00f8], mem[16'h00f7]}, 32'h0c0c00);
    chk(tw, t0 + 10);
    apb(1'b0, R_IDLE, 32'h0);
    chk(t1, t0 + 12 + int'(r));
    chk(t2, t1 + 1);
    chk(t3, t2 + 1);
    mem[16'h0600] = 8'h00;
    apb(1'b1, R_START, 32'h0600);
    apb(1'b1, R_CTRL, 32'h3);
    repeat (10) @(posedge pclk);
    @(negedge pclk);
    a1 = mem_req.addr;
    @(negedge pclk);
    chk({mem_req.rd, mem_req.addr}, {1'b1, a1 + 16'h1});
    @(posedge pclk);
    rd(R_STATUS, 32'h20);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(R_STATUS, 32'h01);
    rd(R_FLAGS, 32'hd0);
    $display("test mode and reset done");
    complete_run();
  end
endmodule
